// [logic/irq_ctrl_pkg.sv]
// constants shared by the vectored interrupt controller and its return stack
// Behaviour
// - every source event raises its own request flag
// - accept pushes next address, loads source vector
// - return pops saved address to resume program
// - accepting any interrupt clears global enable
// - blocked requests still latch their flags
// - software re-enabling global allows nested service
// - full stack blocks acknowledging any request
// - cleared global enable disables every source
// - each source has its own enable bit
// - pending requests serviced on second phase pulse
// - usb highest priority, vector 04H
// - timer0 vector 08H, timer1 vector 0CH
// - serial, converter, external share vector 14H
// - play vector 10H, record 18H lowest
// - timer overflow sets flag regardless of enable
// - timer overflow in power-down wakes device unless its flag is already set
// - servicing timer interrupt clears its flag
// - multifunction service clears only group flag
// - usb flag is bit 4 of first control
package irq_ctrl_pkg;
	// widths
	localparam int PC_W = 13;
	localparam int SP_W = 5;
	localparam int STACK_DEPTH = 16;
	localparam int NUM_SRC = 6;
	// register byte offsets
	localparam logic [3:0] OFF_FIRST = 4'h0;
	localparam logic [3:0] OFF_SECOND = 4'h4;
	localparam logic [3:0] OFF_MULTI = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;
	// irq_control_first fields
	localparam int GIE_BIT = 0;
	localparam int USB_EN_BIT = 1;
	localparam int T0_EN_BIT = 2;
	localparam int T1_EN_BIT = 3;
	localparam int USB_FLAG_BIT = 4;
	localparam int T0_FLAG_BIT = 5;
	localparam int T1_FLAG_BIT = 6;
	// irq_control_second fields
	localparam int PLAY_EN_BIT = 0;
	localparam int MF_EN_BIT = 1;
	localparam int REC_EN_BIT = 2;
	localparam int PLAY_FLAG_BIT = 4;
	localparam int MF_FLAG_BIT = 5;
	localparam int REC_FLAG_BIT = 6;
	// multifunction_irq_control fields
	localparam int SER_EN_BIT = 0;
	localparam int AD_EN_BIT = 1;
	localparam int EXT_EN_BIT = 2;
	localparam int SER_FLAG_BIT = 4;
	localparam int AD_FLAG_BIT = 5;
	localparam int EXT_FLAG_BIT = 6;
	// status register fields
	localparam int SP_LSB = 0;
	localparam int FULL_BIT = 5;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [SP_W-1:0] SP_RESET = 5'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	// source index in priority order, 0 is highest
	localparam int SRC_USB = 0;
	localparam int SRC_T0 = 1;
	localparam int SRC_T1 = 2;
	localparam int SRC_PLAY = 3;
	localparam int SRC_MF = 4;
	localparam int SRC_REC = 5;
	// fixed vector addresses
	localparam logic [PC_W-1:0] VEC_USB = 13'h0004;
	localparam logic [PC_W-1:0] VEC_T0 = 13'h0008;
	localparam logic [PC_W-1:0] VEC_T1 = 13'h000C;
	localparam logic [PC_W-1:0] VEC_PLAY = 13'h0010;
	localparam logic [PC_W-1:0] VEC_MF = 13'h0014;
	localparam logic [PC_W-1:0] VEC_REC = 13'h0018;
endpackage : irq_ctrl_pkg

// [logic/irq_return_stack.sv]
// hardware return stack holding interrupted program addresses
`timescale 1ns/100ps
`default_nettype none
module irq_return_stack (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// push side
	input wire logic push,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] push_data,
	// pop side
	input wire logic pop,
	output logic [irq_ctrl_pkg::PC_W-1:0] top_data,
	// occupancy
	output logic [irq_ctrl_pkg::SP_W-1:0] sp,
	output logic full,
	output logic empty
);
	// storage for saved addresses
	logic [irq_ctrl_pkg::PC_W-1:0] mem_ff [irq_ctrl_pkg::STACK_DEPTH];
	logic [irq_ctrl_pkg::SP_W-1:0] sp_ff; // count of saved entries
	logic [irq_ctrl_pkg::SP_W-1:0] nxt_sp;
	logic [irq_ctrl_pkg::SP_W-1:0] top_idx; // index of newest entry

	// occupancy flags from the pointer
	always_comb begin
		full = (sp_ff == irq_ctrl_pkg::SP_W'(irq_ctrl_pkg::STACK_DEPTH));
		empty = (sp_ff == irq_ctrl_pkg::SP_RESET);
		top_idx = sp_ff - 5'h01;
		top_data = empty ? irq_ctrl_pkg::PC_RESET : mem_ff[top_idx[3:0]];
		sp = sp_ff;
	end

	// pointer moves up on push, down on pop; overflow and underflow ignored
	always_comb begin
		nxt_sp = sp_ff;
		if (push && !full) begin
			nxt_sp = sp_ff + 5'h01;
		end else if (pop && !empty) begin
			nxt_sp = sp_ff - 5'h01;
		end
	end

	// stack pointer register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sp_ff <= irq_ctrl_pkg::SP_RESET;
		end else begin
			sp_ff <= nxt_sp;
		end
	end

	// entry written at the free slot
	always_ff @(posedge clk) begin
		if (push && !full) begin
			mem_ff[sp_ff[3:0]] <= push_data;
		end
	end
endmodule : irq_return_stack
`default_nettype wire

// [logic/vectored_interrupt_controller.sv]
// prioritised vectored interrupt controller with avalon register slave
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_controller (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// avalon-mm register slave
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// processor core
	input wire logic SECOND_PHASE,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] NEXT_PC,
	input wire logic RETURN_IRQ,
	output logic IRQ_TAKEN,
	output logic [irq_ctrl_pkg::PC_W-1:0] IRQ_VECTOR,
	output logic RESUME_VALID,
	output logic [irq_ctrl_pkg::PC_W-1:0] RESUME_PC,
	// request sources
	input wire logic USB_EVENT,
	input wire logic TIMER0_OVERFLOW,
	input wire logic TIMER1_OVERFLOW,
	input wire logic PLAY_EVENT,
	input wire logic RECORD_EVENT,
	input wire logic SERIAL_EVENT,
	input wire logic AD_DONE,
	input wire logic EXT_PIN,
	// power management
	input wire logic POWER_DOWN,
	output logic WAKE
);
	// bus handshake state
	logic wait_ff; // waitrequest register, high while idle
	logic [31:0] rdata_ff; // read data register
	logic bus_done; // edge at which the master sees waitrequest low
	logic wr_en; // write strobe on lane 0
	logic [7:0] wdata; // low byte of write data
	logic wr_first; // write to irq_control_first
	logic wr_second; // write to irq_control_second
	logic wr_multi; // write to multifunction_irq_control
	logic [31:0] nxt_rdata; // decoded read value

	// irq_control_first bits
	logic global_irq_enable_ff;
	logic usb_en_ff;
	logic t0_en_ff;
	logic t1_en_ff;
	logic usb_request_flag_ff;
	logic timer_zero_request_flag_ff;
	logic timer_one_request_flag_ff;
	// irq_control_second bits
	logic play_en_ff;
	logic mf_en_ff;
	logic rec_en_ff;
	logic play_flag_ff;
	logic multifunction_request_flag_ff;
	logic rec_flag_ff;
	// multifunction_irq_control bits
	logic ser_en_ff;
	logic ad_en_ff;
	logic ext_en_ff;
	logic ser_flag_ff;
	logic ad_flag_ff;
	logic ext_flag_ff;

	// external pin edge detection
	logic ext_prev_ff; // previous pin level
	logic ext_fall; // falling edge seen this cycle
	logic mf_event; // any enabled group member fired

	// arbitration
	logic [irq_ctrl_pkg::NUM_SRC-1:0] src_en; // per source enable
	logic [irq_ctrl_pkg::NUM_SRC-1:0] src_flag; // per source request
	logic [irq_ctrl_pkg::NUM_SRC-1:0] pending; // enabled and requested
	logic [irq_ctrl_pkg::NUM_SRC-1:0] grant; // one-hot winner
	logic [irq_ctrl_pkg::NUM_SRC-1:0] svc_clr; // flag cleared by service
	logic [irq_ctrl_pkg::PC_W-1:0] grant_vec; // vector of the winner
	logic accept; // interrupt accepted this cycle

	// stack signals
	logic [irq_ctrl_pkg::PC_W-1:0] stack_top;
	logic [irq_ctrl_pkg::SP_W-1:0] stack_sp;
	logic stack_full;
	logic stack_empty;

	// output registers
	logic irq_taken_ff;
	logic [irq_ctrl_pkg::PC_W-1:0] irq_vector_ff;
	logic resume_valid_ff;
	logic [irq_ctrl_pkg::PC_W-1:0] resume_pc_ff;
	logic wake_ff;

	// bus decode; writes land only at the completing edge
	always_comb begin
		bus_done = (AVS_READ || AVS_WRITE) && !wait_ff;
		wr_en = AVS_WRITE && !wait_ff && AVS_BYTEENABLE[0];
		wdata = AVS_WRITEDATA[7:0];
		wr_first = 1'b0;
		wr_second = 1'b0;
		wr_multi = 1'b0;
		if (AVS_ADDRESS == irq_ctrl_pkg::OFF_FIRST) begin
			wr_first = wr_en;
		end else if (AVS_ADDRESS == irq_ctrl_pkg::OFF_SECOND) begin
			wr_second = wr_en;
		end else if (AVS_ADDRESS == irq_ctrl_pkg::OFF_MULTI) begin
			wr_multi = wr_en;
		end
	end

	// read image of every register; unmapped addresses read zero
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (AVS_ADDRESS == irq_ctrl_pkg::OFF_FIRST) begin
			nxt_rdata[irq_ctrl_pkg::GIE_BIT] = global_irq_enable_ff;
			nxt_rdata[irq_ctrl_pkg::USB_EN_BIT] = usb_en_ff;
			nxt_rdata[irq_ctrl_pkg::T0_EN_BIT] = t0_en_ff;
			nxt_rdata[irq_ctrl_pkg::T1_EN_BIT] = t1_en_ff;
			nxt_rdata[irq_ctrl_pkg::USB_FLAG_BIT] = usb_request_flag_ff;
			nxt_rdata[irq_ctrl_pkg::T0_FLAG_BIT] = timer_zero_request_flag_ff;
			nxt_rdata[irq_ctrl_pkg::T1_FLAG_BIT] = timer_one_request_flag_ff;
		end else if (AVS_ADDRESS == irq_ctrl_pkg::OFF_SECOND) begin
			nxt_rdata[irq_ctrl_pkg::PLAY_EN_BIT] = play_en_ff;
			nxt_rdata[irq_ctrl_pkg::MF_EN_BIT] = mf_en_ff;
			nxt_rdata[irq_ctrl_pkg::REC_EN_BIT] = rec_en_ff;
			nxt_rdata[irq_ctrl_pkg::PLAY_FLAG_BIT] = play_flag_ff;
			nxt_rdata[irq_ctrl_pkg::MF_FLAG_BIT] = multifunction_request_flag_ff;
			nxt_rdata[irq_ctrl_pkg::REC_FLAG_BIT] = rec_flag_ff;
		end else if (AVS_ADDRESS == irq_ctrl_pkg::OFF_MULTI) begin
			nxt_rdata[irq_ctrl_pkg::SER_EN_BIT] = ser_en_ff;
			nxt_rdata[irq_ctrl_pkg::AD_EN_BIT] = ad_en_ff;
			nxt_rdata[irq_ctrl_pkg::EXT_EN_BIT] = ext_en_ff;
			nxt_rdata[irq_ctrl_pkg::SER_FLAG_BIT] = ser_flag_ff;
			nxt_rdata[irq_ctrl_pkg::AD_FLAG_BIT] = ad_flag_ff;
			nxt_rdata[irq_ctrl_pkg::EXT_FLAG_BIT] = ext_flag_ff;
		end else if (AVS_ADDRESS == irq_ctrl_pkg::OFF_STATUS) begin
			nxt_rdata[irq_ctrl_pkg::SP_LSB +: irq_ctrl_pkg::SP_W] = stack_sp;
			nxt_rdata[irq_ctrl_pkg::FULL_BIT] = stack_full;
		end
	end

	// waitrequest drops for one cycle, one cycle after a request rises
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else if (bus_done) begin
			wait_ff <= 1'b1;
		end else if ((AVS_READ || AVS_WRITE) && wait_ff) begin
			wait_ff <= 1'b0;
			rdata_ff <= nxt_rdata;
		end
	end

	// external pin falling edge; idle level high
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ext_prev_ff <= 1'b1;
		end else begin
			ext_prev_ff <= EXT_PIN;
		end
	end

	// source vectors and priority pick
	always_comb begin
		ext_fall = ext_prev_ff && !EXT_PIN;
		mf_event = (SERIAL_EVENT && ser_en_ff) || (AD_DONE && ad_en_ff) || (ext_fall && ext_en_ff);
		src_en = {rec_en_ff, mf_en_ff, play_en_ff, t1_en_ff, t0_en_ff, usb_en_ff};
		src_flag = {rec_flag_ff, multifunction_request_flag_ff, play_flag_ff,
			timer_one_request_flag_ff, timer_zero_request_flag_ff, usb_request_flag_ff};
		pending = src_en & src_flag;
		grant = '0;
		// lowest index wins when several are pending
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				grant = '0;
				grant[i] = 1'b1;
			end
		end
		// accept only on the phase pulse, with global enable, room on stack
		accept = SECOND_PHASE && global_irq_enable_ff && !stack_full && !RETURN_IRQ
			&& (pending != '0);
		svc_clr = accept ? grant : '0;
	end

	// vector of the granted source
	always_comb begin
		grant_vec = irq_ctrl_pkg::VEC_REC;
		if (grant[irq_ctrl_pkg::SRC_USB]) begin
			grant_vec = irq_ctrl_pkg::VEC_USB;
		end else if (grant[irq_ctrl_pkg::SRC_T0]) begin
			grant_vec = irq_ctrl_pkg::VEC_T0;
		end else if (grant[irq_ctrl_pkg::SRC_T1]) begin
			grant_vec = irq_ctrl_pkg::VEC_T1;
		end else if (grant[irq_ctrl_pkg::SRC_PLAY]) begin
			grant_vec = irq_ctrl_pkg::VEC_PLAY;
		end else if (grant[irq_ctrl_pkg::SRC_MF]) begin
			grant_vec = irq_ctrl_pkg::VEC_MF;
		end
	end

	// global enable: hardware clears on accept, software may set again
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			global_irq_enable_ff <= irq_ctrl_pkg::CTRL_RESET[0];
		end else if (accept) begin
			global_irq_enable_ff <= 1'b0;
		end else if (wr_first) begin
			global_irq_enable_ff <= wdata[irq_ctrl_pkg::GIE_BIT];
		end
	end

	// individual enable bits, software owned
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			usb_en_ff <= 1'b0;
			t0_en_ff <= 1'b0;
			t1_en_ff <= 1'b0;
			play_en_ff <= 1'b0;
			mf_en_ff <= 1'b0;
			rec_en_ff <= 1'b0;
			ser_en_ff <= 1'b0;
			ad_en_ff <= 1'b0;
			ext_en_ff <= 1'b0;
		end else begin
			if (wr_first) begin
				usb_en_ff <= wdata[irq_ctrl_pkg::USB_EN_BIT];
				t0_en_ff <= wdata[irq_ctrl_pkg::T0_EN_BIT];
				t1_en_ff <= wdata[irq_ctrl_pkg::T1_EN_BIT];
			end
			if (wr_second) begin
				play_en_ff <= wdata[irq_ctrl_pkg::PLAY_EN_BIT];
				mf_en_ff <= wdata[irq_ctrl_pkg::MF_EN_BIT];
				rec_en_ff <= wdata[irq_ctrl_pkg::REC_EN_BIT];
			end
			if (wr_multi) begin
				ser_en_ff <= wdata[irq_ctrl_pkg::SER_EN_BIT];
				ad_en_ff <= wdata[irq_ctrl_pkg::AD_EN_BIT];
				ext_en_ff <= wdata[irq_ctrl_pkg::EXT_EN_BIT];
			end
		end
	end

	// request flags: event beats service clear beats software write
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			usb_request_flag_ff <= 1'b0;
			timer_zero_request_flag_ff <= 1'b0;
			timer_one_request_flag_ff <= 1'b0;
			play_flag_ff <= 1'b0;
			multifunction_request_flag_ff <= 1'b0;
			rec_flag_ff <= 1'b0;
		end else begin
			usb_request_flag_ff <= USB_EVENT || (!svc_clr[irq_ctrl_pkg::SRC_USB]
				&& (wr_first ? wdata[irq_ctrl_pkg::USB_FLAG_BIT] : usb_request_flag_ff));
			timer_zero_request_flag_ff <= TIMER0_OVERFLOW || (!svc_clr[irq_ctrl_pkg::SRC_T0]
				&& (wr_first ? wdata[irq_ctrl_pkg::T0_FLAG_BIT]
				: timer_zero_request_flag_ff));
			timer_one_request_flag_ff <= TIMER1_OVERFLOW || (!svc_clr[irq_ctrl_pkg::SRC_T1]
				&& (wr_first ? wdata[irq_ctrl_pkg::T1_FLAG_BIT]
				: timer_one_request_flag_ff));
			play_flag_ff <= PLAY_EVENT || (!svc_clr[irq_ctrl_pkg::SRC_PLAY]
				&& (wr_second ? wdata[irq_ctrl_pkg::PLAY_FLAG_BIT] : play_flag_ff));
			multifunction_request_flag_ff <= mf_event || (!svc_clr[irq_ctrl_pkg::SRC_MF]
				&& (wr_second ? wdata[irq_ctrl_pkg::MF_FLAG_BIT]
				: multifunction_request_flag_ff));
			rec_flag_ff <= RECORD_EVENT || (!svc_clr[irq_ctrl_pkg::SRC_REC]
				&& (wr_second ? wdata[irq_ctrl_pkg::REC_FLAG_BIT] : rec_flag_ff));
		end
	end

	// group member flags stay until software clears them
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ser_flag_ff <= 1'b0;
			ad_flag_ff <= 1'b0;
			ext_flag_ff <= 1'b0;
		end else begin
			ser_flag_ff <= SERIAL_EVENT
				|| (wr_multi ? wdata[irq_ctrl_pkg::SER_FLAG_BIT] : ser_flag_ff);
			ad_flag_ff <= AD_DONE
				|| (wr_multi ? wdata[irq_ctrl_pkg::AD_FLAG_BIT] : ad_flag_ff);
			ext_flag_ff <= ext_fall
				|| (wr_multi ? wdata[irq_ctrl_pkg::EXT_FLAG_BIT] : ext_flag_ff);
		end
	end

	// return stack, pushed on accept and popped on return
	irq_return_stack u_stack (
		.clk(CLK),
		.reset(RESET),
		.push(accept),
		.push_data(NEXT_PC),
		.pop(RETURN_IRQ),
		.top_data(stack_top),
		.sp(stack_sp),
		.full(stack_full),
		.empty(stack_empty)
	);

	// core-facing entry outputs
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_taken_ff <= 1'b0;
			irq_vector_ff <= irq_ctrl_pkg::PC_RESET;
		end else begin
			irq_taken_ff <= accept;
			if (accept) begin
				irq_vector_ff <= grant_vec;
			end
		end
	end

	// core-facing return outputs
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			resume_valid_ff <= 1'b0;
			resume_pc_ff <= irq_ctrl_pkg::PC_RESET;
		end else begin
			resume_valid_ff <= RETURN_IRQ && !stack_empty;
			if (RETURN_IRQ && !stack_empty) begin
				resume_pc_ff <= stack_top;
			end
		end
	end

	// wake on timer overflow in power-down, unless flag already set
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= POWER_DOWN && ((TIMER0_OVERFLOW && !timer_zero_request_flag_ff)
				|| (TIMER1_OVERFLOW && !timer_one_request_flag_ff));
		end
	end

	// drive ports from registers
	always_comb begin
		AVS_READDATA = rdata_ff;
		AVS_WAITREQUEST = wait_ff;
		IRQ_TAKEN = irq_taken_ff;
		IRQ_VECTOR = irq_vector_ff;
		RESUME_VALID = resume_valid_ff;
		RESUME_PC = resume_pc_ff;
		WAKE = wake_ff;
	end
endmodule : vectored_interrupt_controller
`default_nettype wire

// [tb/irq_ctrl_checker_sva.sv]
// port checker for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// register bus
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	// core side
	input wire logic SECOND_PHASE,
	input wire logic RETURN_IRQ,
	input wire logic IRQ_TAKEN,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] IRQ_VECTOR,
	input wire logic RESUME_VALID,
	// wake sources
	input wire logic TIMER0_OVERFLOW,
	input wire logic TIMER1_OVERFLOW,
	input wire logic POWER_DOWN,
	input wire logic WAKE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	logic [4:0] depth_ff; // entries pushed and not yet popped
	// follow stack depth from entry and return pulses
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			depth_ff <= 5'h00;
		end else begin
			depth_ff <= depth_ff + 5'(IRQ_TAKEN) - 5'(RESUME_VALID);
		end
	end
	a_taken_on_phase: assert property (IRQ_TAKEN |-> $past(SECOND_PHASE) && !$past(RETURN_IRQ))
		else $error("entry without phase pulse");
	a_taken_single: assert property (IRQ_TAKEN |=> !IRQ_TAKEN)
		else $error("second entry with global enable cleared");
	a_vector_legal: assert property (IRQ_TAKEN |-> IRQ_VECTOR inside {13'h0004, 13'h0008,
		13'h000C, 13'h0010, 13'h0014, 13'h0018}) else $error("entry vector not a source vector");
	a_vector_held: assert property (!IRQ_TAKEN |-> $stable(IRQ_VECTOR))
		else $error("vector moved without entry");
	a_stack_room: assert property (IRQ_TAKEN |-> depth_ff < 5'h10)
		else $error("entry with a full stack");
	a_pop_saved: assert property (RESUME_VALID |-> $past(RETURN_IRQ) && depth_ff != 5'h00)
		else $error("resume without return or saved entry");
	a_no_clash: assert property (RESUME_VALID |-> !IRQ_TAKEN)
		else $error("entry taken with a return");
	a_wake_cause: assert property (WAKE |-> $past(POWER_DOWN) &&
		($past(TIMER0_OVERFLOW) || $past(TIMER1_OVERFLOW))) else $error("wake without overflow");
	a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered");
	a_bus_release: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
endmodule : irq_ctrl_checker
bind vectored_interrupt_controller irq_ctrl_checker chk_u (.CLK(CLK), .RESET(RESET),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.SECOND_PHASE(SECOND_PHASE), .RETURN_IRQ(RETURN_IRQ), .IRQ_TAKEN(IRQ_TAKEN),
	.IRQ_VECTOR(IRQ_VECTOR), .RESUME_VALID(RESUME_VALID), .TIMER0_OVERFLOW(TIMER0_OVERFLOW),
	.TIMER1_OVERFLOW(TIMER1_OVERFLOW), .POWER_DOWN(POWER_DOWN), .WAKE(WAKE));
`default_nettype wire

// [tb/core_model.sv]
// processor core model: phase pulses, saved address and return pulses
`timescale 1ns/100ps
`default_nettype none
module core_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// return request from the bench
	input wire logic ret_req,
	// core outputs
	output logic second_phase,
	output logic [irq_ctrl_pkg::PC_W-1:0] next_pc,
	output logic return_irq
);
	integer seed = 32'h9115327c; // fixed seed for program addresses
	logic [1:0] cnt_ff; // machine cycle position
	// one phase pulse every fourth clock, a fresh address every clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 2'h0;
			second_phase <= 1'b0;
			return_irq <= 1'b0;
			next_pc <= 13'h0000;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			second_phase <= (cnt_ff == 2'h3);
			return_irq <= ret_req;
			next_pc <= 13'($random(seed));
		end
	end
endmodule : core_model
`default_nettype wire

// [tb/vectored_interrupt_controller_tb.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_controller_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] av_addr = 4'h0;
	logic [3:0] av_be = 4'hF;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h00000000;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [7:0] ev = 8'h00; // event pulses, bit 7 pulls the external pin low
	logic pd = 1'b0; // power-down level
	logic ret_req = 1'b0; // asks the core model for a return
	logic phase, ret_irq, taken, resume, wake;
	logic [12:0] npc, vec, rpc;
	integer seed = 32'h9115327c; // random upper write lanes
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int wake_seen = 0;
	int k;
	logic [12:0] exp_vec[$]; // expected entry vectors
	logic [31:0] exp_rd[$]; // expected read data
	logic [12:0] pcs[$]; // reference return stack
	logic [12:0] pc_prev = 13'h0000;
	// per source: event, first, second, multifunction control values
	logic [7:0] tab [8][4] = '{'{8'h01, 8'h03, 8'h00, 8'h00}, '{8'h02, 8'h05, 8'h00, 8'h00},
		'{8'h04, 8'h09, 8'h00, 8'h00}, '{8'h08, 8'h01, 8'h01, 8'h00},
		'{8'h10, 8'h01, 8'h04, 8'h00}, '{8'h20, 8'h01, 8'h02, 8'h01},
		'{8'h40, 8'h01, 8'h02, 8'h02}, '{8'h80, 8'h01, 8'h02, 8'h04}};
	logic [12:0] vtab [8] = '{irq_ctrl_pkg::VEC_USB, irq_ctrl_pkg::VEC_T0, irq_ctrl_pkg::VEC_T1,
		irq_ctrl_pkg::VEC_PLAY, irq_ctrl_pkg::VEC_REC, irq_ctrl_pkg::VEC_MF,
		irq_ctrl_pkg::VEC_MF, irq_ctrl_pkg::VEC_MF};
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	vectored_interrupt_controller dut_u (.CLK(clk), .RESET(rst), .AVS_ADDRESS(av_addr),
		.AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_BYTEENABLE(av_be),
		.AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .SECOND_PHASE(phase),
		.NEXT_PC(npc), .RETURN_IRQ(ret_irq), .IRQ_TAKEN(taken), .IRQ_VECTOR(vec),
		.RESUME_VALID(resume), .RESUME_PC(rpc), .USB_EVENT(ev[0]), .TIMER0_OVERFLOW(ev[1]),
		.TIMER1_OVERFLOW(ev[2]), .PLAY_EVENT(ev[3]), .RECORD_EVENT(ev[4]), .SERIAL_EVENT(ev[5]),
		.AD_DONE(ev[6]), .EXT_PIN(~ev[7]), .POWER_DOWN(pd), .WAKE(wake));
	core_model core_u (.clk(clk), .reset(rst), .ret_req(ret_req), .second_phase(phase),
		.next_pc(npc), .return_irq(ret_irq));
	// compare one value and count it
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	// verdict and end of run
	task automatic print_verdict();
		if (fail_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge clk);
		av_addr <= a;
		av_be <= be;
		av_wdata <= {24'($random(seed)), d};
		av_rd <= ~wr;
		av_wr <= wr;
		do @(posedge clk); while (av_wait !== 1'b0);
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_rd.push_back({24'h000000, e});
		bus(1'b0, a, 8'h00, 4'hF);
	endtask : rd
	// one-cycle event pulse on the sources in m
	task automatic fire(input logic [7:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
	endtask : fire
	// wait until only left expected entries remain, bounded
	task automatic drain(input int left);
		k = 0;
		while (exp_vec.size() > left && k < 60) begin
			@(posedge clk);
			k++;
		end
	endtask : drain
	task automatic ret();
		@(posedge clk);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : ret
	// output monitor: takes the oldest note when a result shows, the newest saved address on a resume
	always @(posedge clk) begin
		if (av_rd && av_wait === 1'b0) check(av_rdata, exp_rd.pop_front());
		if (resume === 1'b1) check(rpc, pcs.pop_back());
		if (taken === 1'b1) begin
			pcs.push_back(pc_prev);
			check(vec, exp_vec.size() != 0 ? exp_vec.pop_front() : 13'h1FFF);
		end
		if (wake === 1'b1) wake_seen++;
		pc_prev = npc;
	end
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped place, lane-0 write refused
		rd(4'h0, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h8, 8'h00);
		rd(4'hC, 8'h00);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h00);
		bus(1'b1, 4'h4, 8'h07, 4'hE);
		rd(4'h4, 8'h00);
		// every source alone: vector, source flags cleared, group member flags kept, global enable cleared
		for (int i = 0; i < 8; i++) begin
			wr(4'h8, tab[i][3]);
			wr(4'h4, tab[i][2]);
			exp_vec.push_back(vtab[i]);
			wr(4'h0, tab[i][1]);
			fire(tab[i][0]);
			drain(0);
			rd(4'h0, tab[i][1] & 8'hFE);
			rd(4'h4, tab[i][2]);
			rd(4'h8, tab[i][3] | (tab[i][3] << 4));
			wr(4'h8, 8'h00);
		end
		// usb and play together, then nesting by re-enabling
		wr(4'h4, 8'h01);
		exp_vec.push_back(irq_ctrl_pkg::VEC_USB);
		exp_vec.push_back(irq_ctrl_pkg::VEC_PLAY);
		wr(4'h0, 8'h03);
		fire(8'h09);
		drain(1);
		wr(4'h0, 8'h03);
		drain(0);
		// blocked requests still latch, then serviced on enable
		wr(4'h4, 8'h00);
		wr(4'h0, 8'h04);
		fire(8'h07);
		repeat (10) @(posedge clk);
		rd(4'h0, 8'h74);
		exp_vec.push_back(irq_ctrl_pkg::VEC_T0);
		wr(4'h0, 8'h75);
		drain(0);
		rd(4'h0, 8'h54);
		// wake from power-down, and the preset flag that suppresses it
		wr(4'h0, 8'h00);
		pd <= 1'b1;
		fire(8'h02);
		fire(8'h04);
		wr(4'h0, 8'h60);
		fire(8'h06);
		repeat (3) @(posedge clk);
		pd <= 1'b0;
		check(wake_seen, 2);
		// eleven entries are still saved from above; five more fill the stack
		for (int i = 0; i < 5; i++) begin
			exp_vec.push_back(irq_ctrl_pkg::VEC_USB);
			wr(4'h0, 8'h03);
			fire(8'h01);
			drain(0);
		end
		wr(4'h0, 8'h03);
		fire(8'h01);
		repeat (12) @(posedge clk);
		rd(4'hC, 8'h30);
		exp_vec.push_back(irq_ctrl_pkg::VEC_USB);
		ret();
		drain(0);
		repeat (16) ret();
		rd(4'hC, 8'h00);
		check(exp_vec.size(), 0);
		check(pcs.size(), 0);
		print_verdict();
	end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire
